//--- src/ilsb_pkg.sv
// shared constants and carrier types for the segmented packet bus core
package ilsb_pkg;
    localparam int ILSB_NSEG = 4;
    localparam int ILSB_SEG_W = 128;
    localparam int ILSB_CHAN_W = 11;
    localparam int ILSB_MTY_W = 4;
    localparam int ILSB_BURST_W = 8;
    // error packets keep only the top bit of the empty count
    localparam logic [3:0] ILSB_MTY_ERR_MASK = 4'h8;
    localparam logic [3:0] ILSB_MTY_ZERO = 4'h0;
    localparam int ILSB_TXQ_DEPTH = 16;
    localparam int ILSB_TXQ_AW = 4;
    localparam logic [3:0] ILSB_PTR_ONE = 4'h1;
    localparam logic [4:0] ILSB_FILL_ONE = 5'h01;
    localparam logic [4:0] ILSB_TXQ_FULL = 5'h10;
    // ready drops at this fill; 8 late writes still stay below overflow
    localparam logic [4:0] ILSB_RDY_OFF_LVL = 5'h02;
    localparam logic [4:0] ILSB_OVF_LVL = 5'h0b;
    localparam logic [7:0] ILSB_BURST_ONE = 8'h01;
    localparam logic [7:0] ILSB_BURST_STEP = 8'h01;

    typedef struct packed {
        logic [ILSB_SEG_W-1:0] data;
        logic [ILSB_CHAN_W-1:0] chan;
        logic ena;
        logic sop;
        logic eop;
        logic err;
        logic [ILSB_MTY_W-1:0] mty;
    } ilsb_seg_t;

    typedef ilsb_seg_t [ILSB_NSEG-1:0] ilsb_bus_t;

    typedef struct packed {
        ilsb_seg_t seg;
        logic bcw;
    } ilsb_tseg_t;

    typedef ilsb_tseg_t [ILSB_NSEG-1:0] ilsb_tword_t;
endpackage

//--- src/ilsb_skid.sv
// two-entry buffer, both outputs straight from flops
`timescale 1ns/1ps
module ilsb_skid #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic [W-1:0] tail_q;
    logic tail_v_q;
    logic push;
    logic pop;

    assign in_ready = ~tail_v_q;
    assign push = in_valid & ~tail_v_q;
    assign pop = out_valid & out_ready;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            out_valid <= 1'b0;
            tail_v_q <= 1'b0;
        end else if (!out_valid || pop) begin
            out_valid <= tail_v_q | push;
            tail_v_q <= 1'b0;
        end else if (push) begin
            tail_v_q <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            out_data <= '0;
            tail_q <= '0;
        end else if (!out_valid || pop) begin
            out_data <= tail_v_q ? tail_q : in_data;
        end else if (push) begin
            tail_q <= in_data;
        end
    end
endmodule // ilsb_skid

//--- src/ilsb_core.sv
// segmented packet bus core: transmit capture and queue, receive delivery
`timescale 1ns/1ps
// Summary of operation
// - transmit segment fields are taken only when that segment's valid is high
// - transmit error is looked at only with valid and end both high
// - transmit empty count is taken only with valid and end high
// - end plus error forces the low three empty bits to zero
// - forced control flag with valid inserts a burst control word first
// - receive valid qualifies every other receive output of its segment
// - receive channel shows the channel of the packet in flight
// - receive start marks first transfer, receive end the last
// - receive error flags an errored packet, meaningful only with end
// - receive empty count; low three bits zero while error and valid
// - any packet length accepted, all inputs registered on rising edge
// - first byte sits in bits 127:120, later bytes lower
// - empty count n marks the n lowest bytes invalid
// - error with end and valid marks the packet as errored
// - overflow is raised on back-pressure violation, threshold 11
// - four parallel 128-bit segments, each with its own qualifiers
module ilsb_core (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // user transmit segments
    input wire ilsb_pkg::ilsb_bus_t tx_bus,
    input wire logic [ilsb_pkg::ILSB_NSEG-1:0] tx_force_bcw,
    input wire logic [ilsb_pkg::ILSB_BURST_W-1:0] maximum_burst_size,
    output logic tx_ready,
    output logic tx_overflow,
    // lane-side transmit egress
    output ilsb_pkg::ilsb_tword_t eg_word,
    output logic eg_valid,
    input wire logic eg_ready,
    // lane-side receive in, user receive out
    input wire ilsb_pkg::ilsb_bus_t rl_bus,
    output ilsb_pkg::ilsb_bus_t rx_bus
);
    import ilsb_pkg::*;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    ilsb_tword_t cap_w;
    ilsb_tword_t q_mem [ILSB_TXQ_DEPTH];
    logic [ILSB_NSEG-1:0] tx_ena;
    logic [ILSB_TXQ_AW-1:0] wr_q;
    logic [ILSB_TXQ_AW-1:0] rd_q;
    logic [ILSB_TXQ_AW:0] fill_q;
    logic [ILSB_TXQ_AW:0] fill_d;
    logic tx_any;
    logic q_full;
    logic q_push;
    logic q_pop;
    logic sk_ready;

    genvar s;

    // ---- transmit capture, one lane per segment
    // four segment lanes
    generate
        for (s = 0; s < ILSB_NSEG; s++) begin : g_tx
            ilsb_tseg_t cw;
            logic [ILSB_CHAN_W-1:0] last_chan_q;
            logic [ILSB_BURST_W-1:0] burst_cnt_q;
            logic size_hit;

            assign tx_ena[s] = tx_bus[s].ena;
            assign size_hit = (maximum_burst_size != '0) &&
                              (burst_cnt_q >= maximum_burst_size);

            always_comb begin
                cw = '0;
                if (tx_bus[s].ena) begin
                    cw.seg.data = tx_bus[s].data;
                    cw.seg.chan = tx_bus[s].chan;
                    cw.seg.ena = 1'b1;
                    cw.seg.sop = tx_bus[s].sop;
                    cw.seg.eop = tx_bus[s].eop;
                    cw.seg.err = tx_bus[s].eop & tx_bus[s].err;
                    if (tx_bus[s].eop) begin
                        cw.seg.mty = tx_bus[s].mty;
                    end
                    if (tx_bus[s].eop && tx_bus[s].err) begin
                        cw.seg.mty = tx_bus[s].mty & ILSB_MTY_ERR_MASK;
                    end
                    cw.bcw = tx_force_bcw[s] | tx_bus[s].sop | size_hit |
                             (tx_bus[s].chan != last_chan_q);
                end
            end

            assign cap_w[s] = cw;

            // words since the last control word, per segment
            always_ff @(posedge sys_clk) begin
                if (!nrst) begin
                    burst_cnt_q <= '0;
                end else if (tx_bus[s].ena) begin
                    if (cw.bcw) begin
                        burst_cnt_q <= ILSB_BURST_ONE;
                    end else begin
                        burst_cnt_q <= burst_cnt_q + ILSB_BURST_STEP;
                    end
                end
            end

            always_ff @(posedge sys_clk) begin
                if (!nrst) begin
                    last_chan_q <= '0;
                end else if (tx_bus[s].ena) begin
                    last_chan_q <= tx_bus[s].chan;
                end
            end

            property p_tx_err_gate;
                tx_bus[s].ena && !tx_bus[s].eop && !q_full |=>
                    !q_mem[wr_q - ILSB_PTR_ONE][s].seg.err &&
                    q_mem[wr_q - ILSB_PTR_ONE][s].seg.mty == ILSB_MTY_ZERO;
            endproperty
            a_tx_err_gate: assert property (p_tx_err_gate)
                else $error("tx error or empty kept without end");

            property p_tx_mty_err;
                tx_bus[s].ena && tx_bus[s].eop && tx_bus[s].err && !q_full |=>
                    q_mem[wr_q - ILSB_PTR_ONE][s].seg.mty ==
                    ($past(tx_bus[s].mty) & ILSB_MTY_ERR_MASK) &&
                    q_mem[wr_q - ILSB_PTR_ONE][s].seg.err;
            endproperty
            a_tx_mty_err: assert property (p_tx_mty_err)
                else $error("tx empty low bits not cleared on error");

            property p_tx_mty_keep;
                tx_bus[s].ena && tx_bus[s].eop && !tx_bus[s].err && !q_full |=>
                    q_mem[wr_q - ILSB_PTR_ONE][s].seg.mty == $past(tx_bus[s].mty);
            endproperty
            a_tx_mty_keep: assert property (p_tx_mty_keep)
                else $error("tx empty count lost at end");

            property p_tx_bcw;
                tx_bus[s].ena && tx_force_bcw[s] && !q_full |=>
                    q_mem[wr_q - ILSB_PTR_ONE][s].bcw;
            endproperty
            a_tx_bcw: assert property (p_tx_bcw)
                else $error("forced control word missing");

            property p_tx_idle_seg;
                !tx_bus[s].ena && !q_full && tx_any |=>
                    q_mem[wr_q - ILSB_PTR_ONE][s] == '0;
            endproperty
            a_tx_idle_seg: assert property (p_tx_idle_seg)
                else $error("idle tx segment captured");
        end
    endgenerate

    // ---- transmit queue toward the lanes
    assign tx_any = |tx_ena;
    assign q_full = (fill_q == ILSB_TXQ_FULL);
    assign q_push = tx_any & ~q_full;
    assign q_pop = (fill_q != '0) & sk_ready;

    always_ff @(posedge sys_clk) begin
        if (q_push) begin
            q_mem[wr_q] <= cap_w;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            wr_q <= '0;
        end else if (q_push) begin
            wr_q <= wr_q + ILSB_PTR_ONE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rd_q <= '0;
        end else if (q_pop) begin
            rd_q <= rd_q + ILSB_PTR_ONE;
        end
    end

    always_comb begin
        fill_d = fill_q;
        if (q_push) begin
            fill_d = fill_d + ILSB_FILL_ONE;
        end
        if (q_pop) begin
            fill_d = fill_d - ILSB_FILL_ONE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            fill_q <= '0;
        end else begin
            fill_q <= fill_d;
        end
    end

    // ready falls early enough for 8 late writes
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            tx_ready <= 1'b0;
        end else begin
            tx_ready <= (fill_d < ILSB_RDY_OFF_LVL);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            tx_overflow <= 1'b0;
        end else begin
            tx_overflow <= tx_any && (fill_q >= ILSB_OVF_LVL);
        end
    end

    // lane stall fills the skid, then the queue
    ilsb_skid #(
        .W($bits(ilsb_tword_t))
    ) u_skid (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .in_valid(fill_q != '0),
        .in_ready(sk_ready),
        .in_data(q_mem[rd_q]),
        .out_valid(eg_valid),
        .out_ready(eg_ready),
        .out_data(eg_word)
    );

    property p_tx_push;
        tx_any && !q_full |=> wr_q == $past(wr_q) + ILSB_PTR_ONE;
    endproperty
    a_tx_push: assert property (p_tx_push)
        else $error("tx write not stored");

    property p_tx_hold;
        !tx_any |=> wr_q == $past(wr_q);
    endproperty
    a_tx_hold: assert property (p_tx_hold)
        else $error("tx stored without valid");

    property p_ovf;
        tx_any && fill_q >= ILSB_OVF_LVL |=> tx_overflow;
    endproperty
    a_ovf: assert property (p_ovf)
        else $error("overflow not raised at threshold");

    property p_no_ovf;
        fill_q < ILSB_OVF_LVL |=> !tx_overflow;
    endproperty
    a_no_ovf: assert property (p_no_ovf)
        else $error("overflow raised below threshold");

    // ---- receive delivery, one lane per segment
    generate
        for (s = 0; s < ILSB_NSEG; s++) begin : g_rx
            ilsb_seg_t rq;

            assign rx_bus[s] = rq;

            always_ff @(posedge sys_clk) begin
                if (!nrst) begin
                    rq <= '0;
                end else if (!rl_bus[s].ena) begin
                    rq <= '0;
                end else begin
                    rq.ena <= 1'b1;
                    rq.data <= rl_bus[s].data;
                    rq.chan <= rl_bus[s].chan;
                    rq.sop <= rl_bus[s].sop;
                    rq.eop <= rl_bus[s].eop;
                    rq.err <= rl_bus[s].eop & rl_bus[s].err;
                    if (!rl_bus[s].eop) begin
                        rq.mty <= ILSB_MTY_ZERO;
                    end else if (rl_bus[s].err) begin
                        rq.mty <= rl_bus[s].mty & ILSB_MTY_ERR_MASK;
                    end else begin
                        rq.mty <= rl_bus[s].mty;
                    end
                end
            end

            property p_rx_qual;
                !rl_bus[s].ena |=> !rq.ena && !rq.sop && !rq.eop && !rq.err;
            endproperty
            a_rx_qual: assert property (p_rx_qual)
                else $error("rx qualifiers active without valid");

            property p_rx_chan;
                rl_bus[s].ena |=> rq.ena && rq.chan == $past(rl_bus[s].chan);
            endproperty
            a_rx_chan: assert property (p_rx_chan)
                else $error("rx channel mismatch");

            property p_rx_mty;
                rq.ena && rq.err |-> rq.mty[2:0] == ILSB_MTY_ZERO[2:0] && rq.eop;
            endproperty
            a_rx_mty: assert property (p_rx_mty)
                else $error("rx empty low bits set on error");

            property p_rx_err;
                rl_bus[s].ena && rl_bus[s].eop |=>
                    rq.err == $past(rl_bus[s].err) && rq.eop;
            endproperty
            a_rx_err: assert property (p_rx_err)
                else $error("rx error not passed at end");
        end
    endgenerate

    c_tx_overflow: cover property (tx_any && fill_q >= ILSB_OVF_LVL);
    c_tx_stall: cover property (eg_valid && !eg_ready ##1 !tx_ready);
    c_tx_forced: cover property (tx_ena[0] && tx_force_bcw[0] && tx_bus[0].eop);
    c_rx_err_end: cover property (rx_bus[3].ena && rx_bus[3].err);
endmodule // ilsb_core

//--- tb/ilsb_lane_model.sv
// lane-side sink model: takes egress words promptly, slowly or not at all
`timescale 1ns/1ps
module ilsb_lane_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // egress handshake
    input wire logic eg_valid,
    output logic eg_ready,
    // 0 prompt, 1 random stalls, 2 halted
    input wire logic [1:0] mode
);
    // ready changes only just after an edge; idle cycles keep it up except when halted
    always @(posedge sys_clk) begin
        if (!nrst) begin
            eg_ready <= 1'b0;
        end else begin
            case (mode)
                2'h0: eg_ready <= 1'b1;
                2'h1: eg_ready <= eg_valid ? 1'($urandom_range(1)) : 1'b1;
                default: eg_ready <= 1'b0;
            endcase
        end
    end
endmodule // ilsb_lane_model

//--- tb/ilsb_core_tb_top.sv
// self-checking bench for the segmented packet bus core
`timescale 1ns/1ps
module ilsb_core_tb_top;
    import ilsb_pkg::*;
    logic sys_clk;
    logic nrst;
    ilsb_bus_t tx_bus;
    logic [ILSB_NSEG-1:0] tx_force_bcw;
    logic [ILSB_BURST_W-1:0] maximum_burst_size;
    logic tx_ready;
    logic tx_overflow;
    ilsb_tword_t eg_word;
    logic eg_valid;
    logic eg_ready;
    ilsb_bus_t rl_bus;
    ilsb_bus_t rx_bus;
    logic [1:0] lane_mode;
    logic ovf_now;
    int fails;
    int samples_checked;
    int wr_low;
    ilsb_tword_t tx_exp[$];
    ilsb_bus_t rx_exp[$];
    logic [ILSB_CHAN_W-1:0] last_chan [ILSB_NSEG];
    logic [ILSB_BURST_W-1:0] bcnt [ILSB_NSEG];
    logic [ILSB_CHAN_W-1:0] pkt_chan;
    int pkt_left;

    ilsb_core dut (.sys_clk(sys_clk), .nrst(nrst), .tx_bus(tx_bus),
        .tx_force_bcw(tx_force_bcw), .maximum_burst_size(maximum_burst_size),
        .tx_ready(tx_ready), .tx_overflow(tx_overflow), .eg_word(eg_word),
        .eg_valid(eg_valid), .eg_ready(eg_ready), .rl_bus(rl_bus), .rx_bus(rx_bus));

    ilsb_lane_model lane (.sys_clk(sys_clk), .nrst(nrst), .eg_valid(eg_valid),
        .eg_ready(eg_ready), .mode(lane_mode));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // what a segment should look like after qualification
    function automatic ilsb_seg_t clean(input ilsb_seg_t s);
        ilsb_seg_t r;
        r = s.ena ? s : '0;
        if (!r.eop) begin
            r.err = 1'b0;
            r.mty = ILSB_MTY_ZERO;
        end
        if (r.eop && r.err) begin
            r.mty = r.mty & ILSB_MTY_ERR_MASK;
        end
        return r;
    endfunction

    function automatic ilsb_seg_t rnd_seg();
        ilsb_seg_t s;
        s.data = {$urandom, $urandom, $urandom, $urandom};
        s.chan = 11'($urandom_range(2, 1));
        s.ena = 1'($urandom_range(3) != 0);
        {s.sop, s.eop, s.err} = 3'($urandom);
        s.mty = 4'($urandom);
        return s;
    endfunction

    task automatic cmp_tx(input ilsb_tword_t got, input ilsb_tword_t exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_rx(input ilsb_bus_t got, input ilsb_bus_t exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // how: 0 idle, 1 writes while ready, 2 forced write; dirty leaves junk on non-end fields
    task automatic tx_cycle(input logic [1:0] how, input logic dirty);
        ilsb_tword_t w;
        logic go;
        logic hit;
        int used;
        @(negedge sys_clk);
        // writes only while ready unless forced past it
        go = (how == 2'h2) || (how == 2'h1 && tx_ready === 1'b1 && $urandom_range(1) == 1);
        used = go ? $urandom_range(ILSB_NSEG, 1) : 0;
        for (int s = 0; s < ILSB_NSEG; s++) begin
            tx_bus[s] = rnd_seg();
            // defined valid, segments used from zero upward
            tx_bus[s].ena = (s < used);
            if (tx_bus[s].ena) begin
                // start opens a packet, channel held to its end
                tx_bus[s].sop = (pkt_left == 0);
                if (pkt_left == 0) begin
                    pkt_left = $urandom_range(6, 1);
                    pkt_chan = 11'($urandom_range(2, 1));
                end
                tx_bus[s].chan = pkt_chan;
                pkt_left--;
                tx_bus[s].eop = (pkt_left == 0);
                // full data; error and empty count only at the end
                if (!tx_bus[s].eop && !dirty) begin
                    tx_bus[s].err = 1'b0;
                    tx_bus[s].mty = ILSB_MTY_ZERO;
                end
            end
            // outside scheduler places some control words
            tx_force_bcw[s] = 1'($urandom_range(3) == 0);
            w[s].seg = clean(tx_bus[s]);
            hit = (maximum_burst_size != '0) && (bcnt[s] >= maximum_burst_size);
            // forced, start, size or channel change open a burst
            w[s].bcw = tx_bus[s].ena & (tx_force_bcw[s] | tx_bus[s].sop | hit
                | (tx_bus[s].chan != last_chan[s]));
            if (tx_bus[s].ena) begin
                bcnt[s] = w[s].bcw ? ILSB_BURST_ONE : bcnt[s] + ILSB_BURST_STEP;
                last_chan[s] = tx_bus[s].chan;
            end
        end
        if (go) begin
            tx_exp.push_back(w);
        end
    endtask

    task automatic rx_cycle(input logic go);
        ilsb_bus_t e;
        @(negedge sys_clk);
        for (int s = 0; s < ILSB_NSEG; s++) begin
            rl_bus[s] = rnd_seg();
            rl_bus[s].ena = rl_bus[s].ena & go;
            e[s] = clean(rl_bus[s]);
        end
        rx_exp.push_back(e);
    endtask

    task automatic tally_and_finish();
        if (tx_exp.size() != 0) begin
            fails++;
        end
        if (fails == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // egress words taken by the lane side
    always @(posedge sys_clk) begin
        if (nrst === 1'b1 && eg_valid === 1'b1 && eg_ready === 1'b1) begin
            if (tx_exp.size() == 0) begin
                cmp_tx(eg_word, ~eg_word);
            end else begin
                cmp_tx(eg_word, tx_exp.pop_front());
            end
        end
    end

    // receive outputs one edge after the lane input
    always @(posedge sys_clk) begin
        #1;
        if (rx_exp.size() > 0) begin
            cmp_rx(rx_bus, rx_exp.pop_front());
        end
    end

    // run needs well under a thousand cycles
    initial begin
        #(4000 * 50);
        fails++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(32'h81e0));
        nrst = 1'b0;
        tx_bus = '0;
        tx_force_bcw = '0;
        maximum_burst_size = '0;
        rl_bus = '0;
        lane_mode = 2'h0;
        fails = 0;
        samples_checked = 0;
        wr_low = 0;
        pkt_left = 0;
        pkt_chan = '0;
        foreach (last_chan[i]) begin
            last_chan[i] = '0;
            bcnt[i] = '0;
        end
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        nrst = 1'b1;
        // legal packets and lane traffic, prompt lane
        fork
            repeat (80) tx_cycle(2'h1, 1'b0);
            repeat (80) rx_cycle(1'b1);
        join
        tx_cycle(2'h0, 1'b0);
        rx_cycle(1'b0);
        // stalls, junk non-end fields, burst size limit
        lane_mode = 2'h1;
        maximum_burst_size = 8'h03;
        repeat (60) tx_cycle(2'h1, 1'b1);
        lane_mode = 2'h0;
        repeat (20) tx_cycle(2'h0, 1'b0);
        maximum_burst_size = '0;
        cmp_bit(tx_ready, 1'b1);
        // writes past ready with the lane halted
        lane_mode = 2'h2;
        tx_cycle(2'h0, 1'b0);
        ovf_now = 1'b0;
        while (ovf_now !== 1'b1 && wr_low < 12) begin
            if (tx_ready === 1'b0) begin
                wr_low++;
            end
            tx_cycle(2'h2, 1'b0);
            @(posedge sys_clk);
            #1;
            ovf_now = tx_overflow;
            if (wr_low <= 8) begin
                cmp_bit(ovf_now, 1'b0);
            end
        end
        cmp_bit(ovf_now, 1'b1);
        cmp_bit(tx_ready, 1'b0);
        tx_cycle(2'h0, 1'b0);
        @(posedge sys_clk);
        #1;
        cmp_bit(tx_overflow, 1'b0);
        lane_mode = 2'h1;
        for (int i = 0; i < 400 && tx_exp.size() > 0; i++) begin
            @(posedge sys_clk);
        end
        lane_mode = 2'h0;
        repeat (6) @(posedge sys_clk);
        #1;
        cmp_bit(eg_valid, 1'b0);
        cmp_bit(tx_ready, 1'b1);
        tally_and_finish();
    end
endmodule // ilsb_core_tb_top
